// File: design/ofc_frame_regs.sv
// Frame control registers, display page memory and its clear sequencer.
`timescale 1ns/1ns
module ofc_frame_regs
(
  // Clock and reset.
  input  wire logic        CLOCK,
  input  wire logic        RESET_N,
  // Decoded host register access.
  input  wire logic [15:0] HOST_ADDR,
  input  wire logic        HOST_WR,
  input  wire logic [7:0]  HOST_WDATA,
  input  wire logic        HOST_RD,
  output logic      [7:0]  HOST_RDATA,
  output logic             HOST_RVALID,
  // Character renderer page port.
  input  wire logic [8:0]  PAGE_RD_INDEX,
  output logic      [7:0]  PAGE_RD_DATA,
  // Window timing.
  input  wire logic        FIELD_TICK,
  input  wire logic        WIN1_ACTIVE,
  input  wire logic        WIN2_ACTIVE,
  output logic             OSD_ON,
  output logic             WIN1_SHOW,
  output logic             WIN2_SHOW,
  output logic             BLINK_PHASE,
  output logic      [9:0]  PIXELS_PER_LINE,
  output logic             CLEAR_BUSY,
  // Palette mixer.
  input  wire logic [8:0]  PAL_COLOR,
  input  wire logic [3:0]  PAL_INDEX,
  output logic             PAL_TRANSPARENT
);

  logic [7:0]                frame_one_reg;
  logic [7:0]                frame_two_reg;
  logic [7:0]                page_reg [ofc_pkg::PAGE_DEPTH];
  logic [8:0]                clr_idx_reg;
  ofc_pkg::ofc_clr_state_t   clr_state_reg;
  ofc_pkg::ofc_clr_state_t   clr_state_next;
  logic [6:0]                blink_cnt_reg;
  logic [6:0]                blink_half;
  logic                      global_en;
  logic                      wr_one;
  logic                      wr_two;
  logic                      clear_req;

  // True when the address falls inside the display page memory.
  function automatic logic page_hit(input logic [15:0] addr);
    page_hit = (addr >= ofc_pkg::ADDR_PAGE_BASE) && (addr <= ofc_pkg::ADDR_PAGE_LAST);
  endfunction : page_hit

  assign global_en = frame_one_reg[ofc_pkg::BIT_GLOBAL_EN];
  assign wr_one    = HOST_WR && (HOST_ADDR == ofc_pkg::ADDR_FRAME_ONE);
  assign wr_two    = HOST_WR && (HOST_ADDR == ofc_pkg::ADDR_FRAME_TWO);
  assign clear_req = wr_one && HOST_WDATA[ofc_pkg::BIT_PAGE_CLEAR];
  assign CLEAR_BUSY = (clr_state_reg == ofc_pkg::CLR_RUN);

  // The clear bit mirrors the sequencer, so a second request while busy is absorbed.
  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
      frame_one_reg <= ofc_pkg::FRAME_ONE_RST;
    else
    begin
      if (wr_one)
        frame_one_reg <= HOST_WDATA & ofc_pkg::FRAME_ONE_MASK;
      // Taking the bit from the next state rather than the written byte means a write landing
      // in the last clearing cycle cannot leave the bit stuck at one.
      frame_one_reg[ofc_pkg::BIT_PAGE_CLEAR] <= (clr_state_next == ofc_pkg::CLR_RUN);
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
      frame_two_reg <= ofc_pkg::FRAME_TWO_RST;
    else if (wr_two)
      frame_two_reg <= HOST_WDATA;
  end

  always_comb
  begin
    clr_state_next = clr_state_reg;
    case (clr_state_reg)
      ofc_pkg::CLR_IDLE:
      begin
        if (clear_req)
          clr_state_next = ofc_pkg::CLR_RUN;
      end
      ofc_pkg::CLR_RUN:
      begin
        if (clr_idx_reg == ofc_pkg::PAGE_LAST_IDX)
          clr_state_next = ofc_pkg::CLR_IDLE;
      end
      default:
        clr_state_next = ofc_pkg::CLR_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
    begin
      clr_state_reg <= ofc_pkg::CLR_IDLE;
      clr_idx_reg   <= 9'h000;
    end
    else
    begin
      clr_state_reg <= clr_state_next;
      if (CLEAR_BUSY)
        clr_idx_reg <= clr_idx_reg + 9'h001;
      else
        clr_idx_reg <= 9'h000;
    end
  end

  // One location per cycle keeps the memory single-ported; clearing takes 512 cycles.
  // Host writes to the page are dropped while clearing so none survives the clear.
  always_ff @(posedge CLOCK)
  begin
    if (CLEAR_BUSY)
      page_reg[clr_idx_reg] <= 8'h00;
    else if (HOST_WR && page_hit(HOST_ADDR))
      page_reg[HOST_ADDR[8:0]] <= HOST_WDATA;
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
      PAGE_RD_DATA <= 8'h00;
    else
      PAGE_RD_DATA <= page_reg[PAGE_RD_INDEX];
  end

  // Host read data, valid one cycle after the strobe; unmapped addresses read zero.
  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
    begin
      HOST_RDATA  <= 8'h00;
      HOST_RVALID <= 1'b0;
    end
    else
    begin
      HOST_RVALID <= HOST_RD;
      if (HOST_RD)
      begin
        if (HOST_ADDR == ofc_pkg::ADDR_FRAME_ONE)
          HOST_RDATA <= frame_one_reg & ofc_pkg::FRAME_ONE_MASK;
        else if (HOST_ADDR == ofc_pkg::ADDR_FRAME_TWO)
          HOST_RDATA <= frame_two_reg;
        else if (page_hit(HOST_ADDR))
          HOST_RDATA <= page_reg[HOST_ADDR[8:0]];
        else
          HOST_RDATA <= 8'h00;
      end
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
    begin
      OSD_ON    <= 1'b0;
      WIN1_SHOW <= 1'b0;
      WIN2_SHOW <= 1'b0;
    end
    else
    begin
      OSD_ON    <= global_en;
      WIN1_SHOW <= global_en && frame_one_reg[ofc_pkg::BIT_WIN_ONE_EN] && WIN1_ACTIVE;
      WIN2_SHOW <= global_en && frame_one_reg[ofc_pkg::BIT_WIN_TWO_EN] && WIN2_ACTIVE;
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
      PAL_TRANSPARENT <= 1'b0;
    else
      PAL_TRANSPARENT <= !frame_one_reg[ofc_pkg::BIT_TRANSP_DIS] && (PAL_COLOR == ofc_pkg::PAL_BLACK)
                         && (PAL_INDEX < ofc_pkg::TRANSP_IDX_LIMIT);
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
      PIXELS_PER_LINE <= ofc_pkg::PPL_BASE;
    else
      PIXELS_PER_LINE <= ofc_pkg::PPL_BASE
                         + (10'(frame_two_reg[ofc_pkg::RES_MSB:ofc_pkg::RES_LSB]) << ofc_pkg::PPL_STEP_SHL);
  end

  // The phase toggles every four times the field count, so a full on/off cycle is eight times it.
  // A zero count holds the phase low, which stops blinking.
  assign blink_half = 7'(frame_two_reg[ofc_pkg::BLINK_MSB:ofc_pkg::BLINK_LSB]) << ofc_pkg::BLINK_HALF_SHL;

  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
    begin
      blink_cnt_reg <= 7'h00;
      BLINK_PHASE   <= 1'b0;
    end
    else if (blink_half == 7'h00)
    begin
      blink_cnt_reg <= 7'h00;
      BLINK_PHASE   <= 1'b0;
    end
    else if (FIELD_TICK)
    begin
      if (blink_cnt_reg + 7'h01 >= blink_half)
      begin
        blink_cnt_reg <= 7'h00;
        BLINK_PHASE   <= !BLINK_PHASE;
      end
      else
        blink_cnt_reg <= blink_cnt_reg + 7'h01;
    end
  end

  // Helper counter for the clear duration check.
  logic [9:0] busy_len;
  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N || !CLEAR_BUSY)
      busy_len <= 10'h000;
    else
      busy_len <= busy_len + 10'h001;
  end

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESET_N);

  AST_GLOBAL_OFF: assert property (!$past(global_en) |-> !OSD_ON && !WIN1_SHOW && !WIN2_SHOW)
    else $error("window shown while display disabled");
  AST_WIN_ONE: assert property ((global_en && frame_one_reg[ofc_pkg::BIT_WIN_ONE_EN] && WIN1_ACTIVE)
    |=> WIN1_SHOW)
    else $error("window one not shown");
  AST_WIN_TWO: assert property (WIN2_SHOW |-> $past(frame_one_reg[ofc_pkg::BIT_WIN_TWO_EN] && global_en))
    else $error("window two shown without enables");
  AST_CLEAR_START: assert property ((clear_req && !CLEAR_BUSY) |=> CLEAR_BUSY
    && frame_one_reg[ofc_pkg::BIT_PAGE_CLEAR] && clr_idx_reg == 9'h000)
    else $error("clear did not start");
  AST_CLEAR_ZERO: assert property (CLEAR_BUSY |=> page_reg[$past(clr_idx_reg)] == 8'h00)
    else $error("page location not zeroed");
  AST_CLEAR_LEN: assert property (CLEAR_BUSY |-> busy_len < 10'h200)
    else $error("clear ran longer than 512 cycles");
  AST_CLEAR_END: assert property (busy_len == 10'h1ff |=> !CLEAR_BUSY
    && !frame_one_reg[ofc_pkg::BIT_PAGE_CLEAR])
    else $error("clear did not finish in 512 cycles");
  AST_TRANSPARENT: assert property ((PAL_COLOR == 9'h000 && PAL_INDEX < 4'h8
    && !frame_one_reg[ofc_pkg::BIT_TRANSP_DIS]) |=> PAL_TRANSPARENT)
    else $error("black entry not transparent");
  AST_OPAQUE: assert property (frame_one_reg[ofc_pkg::BIT_TRANSP_DIS] |=> !PAL_TRANSPARENT)
    else $error("transparent while disabled");
  AST_BLINK: assert property ((FIELD_TICK && blink_half != 7'h00 && blink_cnt_reg + 7'h01 == blink_half
    && $stable(frame_two_reg)) |=> BLINK_PHASE != $past(BLINK_PHASE) && blink_cnt_reg == 7'h00)
    else $error("blink phase did not toggle");
  AST_PPL: assert property ($stable(frame_two_reg) |=> PIXELS_PER_LINE
    == 10'd512 + 10'd64 * 10'($past(frame_two_reg[7:5])))
    else $error("pixels per line wrong");
  AST_RSV_READ: assert property ((HOST_RD && HOST_ADDR == 16'h8400) |=> HOST_RVALID && HOST_RDATA[7:5] == 3'h0)
    else $error("reserved bits read nonzero");
  AST_CLEAR_BIT: assert property (frame_one_reg[ofc_pkg::BIT_PAGE_CLEAR] == CLEAR_BUSY)
    else $error("clear bit does not follow the sequencer");
  AST_RSV_HOLD: assert property (frame_one_reg[7:5] == 3'h0)
    else $error("reserved bits stored");
  AST_PPL_RANGE: assert property (PIXELS_PER_LINE >= 10'h200 && PIXELS_PER_LINE <= 10'h3c0
    && PIXELS_PER_LINE[5:0] == 6'h00)
    else $error("pixels per line out of range");
  AST_BLINK_STOP: assert property (blink_half == 7'h00 |=> !BLINK_PHASE && blink_cnt_reg == 7'h00)
    else $error("blink running with zero period");
  AST_OSD_FOLLOW: assert property (global_en |=> OSD_ON)
    else $error("display not enabled");
  AST_WIN_TWO_ON: assert property ((global_en && frame_one_reg[ofc_pkg::BIT_WIN_TWO_EN] && WIN2_ACTIVE)
    |=> WIN2_SHOW)
    else $error("window two not shown");
  AST_WIN_ONE_OFF: assert property (WIN1_SHOW |-> $past(frame_one_reg[ofc_pkg::BIT_WIN_ONE_EN] && global_en))
    else $error("window one shown without enables");
  AST_TRANSP_IDX: assert property (PAL_INDEX >= 4'h8 |=> !PAL_TRANSPARENT)
    else $error("transparent above attribute seven");

  COV_CLEAR_DONE: cover property (CLEAR_BUSY ##1 !CLEAR_BUSY);
  COV_BOTH_WINDOWS: cover property (WIN1_SHOW && WIN2_SHOW);
  COV_BLINK_TOGGLE: cover property (BLINK_PHASE ##1 !BLINK_PHASE);
  COV_TRANSPARENT: cover property (PAL_TRANSPARENT);
  COV_PAGE_WR_DROPPED: cover property (CLEAR_BUSY && HOST_WR && page_hit(HOST_ADDR));

endmodule : ofc_frame_regs

// File: include/ofc_pkg.sv
// Package of constants and types for the frame control register bank.
package ofc_pkg;
  // Host addresses.
  localparam logic [15:0] ADDR_FRAME_ONE = 16'h8400;
  localparam logic [15:0] ADDR_FRAME_TWO = 16'h8401;
  localparam logic [15:0] ADDR_PAGE_BASE = 16'h8000;
  localparam logic [15:0] ADDR_PAGE_LAST = 16'h81ff;
  localparam int          PAGE_DEPTH     = 512;
  localparam logic [8:0]  PAGE_LAST_IDX  = 9'h1ff;
  // Field positions of frame_control_one.
  localparam int BIT_GLOBAL_EN   = 0;
  localparam int BIT_WIN_ONE_EN  = 1;
  localparam int BIT_WIN_TWO_EN  = 2;
  localparam int BIT_PAGE_CLEAR  = 3;
  localparam int BIT_TRANSP_DIS  = 4;
  localparam logic [7:0] FRAME_ONE_MASK = 8'h1f;
  // Field positions of frame_control_two.
  localparam int BLINK_LSB = 0;
  localparam int BLINK_MSB = 4;
  localparam int RES_LSB   = 5;
  localparam int RES_MSB   = 7;
  // Reset values.
  localparam logic [7:0] FRAME_ONE_RST = 8'h00;
  localparam logic [7:0] FRAME_TWO_RST = 8'h00;
  // Pixel resolution and blink scaling.
  localparam logic [9:0] PPL_BASE      = 10'h200;
  localparam int         PPL_STEP_SHL  = 6;
  localparam int         BLINK_HALF_SHL = 2;
  // Palette attributes eligible for transparency.
  localparam logic [3:0] TRANSP_IDX_LIMIT = 4'h8;
  localparam logic [8:0] PAL_BLACK = 9'h000;
  // Page clear sequencer.
  typedef enum logic [0:0]
  {
    CLR_IDLE = 1'b0,
    CLR_RUN  = 1'b1
  } ofc_clr_state_t;
endpackage : ofc_pkg

// File: sim/ofc_host_model.sv
// Host microcontroller model issuing decoded byte writes and reads.
`timescale 1ns/1ns
module ofc_host_model
(
  // Clock.
  input  wire logic        CLOCK,
  // Decoded host access.
  output logic      [15:0] HOST_ADDR,
  output logic             HOST_WR,
  output logic      [7:0]  HOST_WDATA,
  output logic             HOST_RD
);
  int slow = 0;
  initial
  begin
    HOST_ADDR = 16'h0000;
    HOST_WDATA = 8'h00;
    HOST_WR = 1'b0;
    HOST_RD = 1'b0;
  end
  task automatic xfer(input logic [15:0] a, input logic [7:0] d, input logic w);
    repeat (slow) @(posedge CLOCK);
    @(posedge CLOCK);
    #1;
    HOST_ADDR = a;
    HOST_WDATA = d;
    HOST_WR = w;
    HOST_RD = !w;
    @(posedge CLOCK);
    #1;
    HOST_WR = 1'b0;
    HOST_RD = 1'b0;
    // Released lines carry the inverse so a stale value is never trusted.
    HOST_ADDR = ~a;
    HOST_WDATA = ~d;
  endtask : xfer
endmodule : ofc_host_model

// File: sim/osd_frame_control_regs_test.sv
// Self-checking testbench for the frame control register bank.
`timescale 1ns/1ns
module osd_frame_control_regs_test;
  logic CLOCK = 1'b0;
  logic RESET_N, HOST_WR, HOST_RD, HOST_RVALID, FIELD_TICK, WIN1_ACTIVE, WIN2_ACTIVE;
  time  t0;
  logic OSD_ON, WIN1_SHOW, WIN2_SHOW, BLINK_PHASE, CLEAR_BUSY, PAL_TRANSPARENT;
  logic [15:0] HOST_ADDR;
  logic [7:0]  HOST_WDATA, HOST_RDATA, PAGE_RD_DATA, d0, d1;
  logic [8:0]  PAGE_RD_INDEX, PAL_COLOR;
  logic [3:0]  PAL_INDEX;
  logic [9:0]  PIXELS_PER_LINE;
  logic [7:0]  exp_q[$];
  int          err_count = 0;
  int          checks = 0;
  int          n;
  ofc_host_model u_host (.CLOCK(CLOCK), .HOST_ADDR(HOST_ADDR), .HOST_WR(HOST_WR), .HOST_WDATA(HOST_WDATA),
                         .HOST_RD(HOST_RD));
  ofc_frame_regs u_dut (.CLOCK(CLOCK), .RESET_N(RESET_N), .HOST_ADDR(HOST_ADDR), .HOST_WR(HOST_WR),
    .HOST_WDATA(HOST_WDATA), .HOST_RD(HOST_RD), .HOST_RDATA(HOST_RDATA), .HOST_RVALID(HOST_RVALID),
    .PAGE_RD_INDEX(PAGE_RD_INDEX), .PAGE_RD_DATA(PAGE_RD_DATA), .FIELD_TICK(FIELD_TICK),
    .WIN1_ACTIVE(WIN1_ACTIVE), .WIN2_ACTIVE(WIN2_ACTIVE), .OSD_ON(OSD_ON), .WIN1_SHOW(WIN1_SHOW),
    .WIN2_SHOW(WIN2_SHOW), .BLINK_PHASE(BLINK_PHASE), .PIXELS_PER_LINE(PIXELS_PER_LINE),
    .CLEAR_BUSY(CLEAR_BUSY), .PAL_COLOR(PAL_COLOR), .PAL_INDEX(PAL_INDEX), .PAL_TRANSPARENT(PAL_TRANSPARENT));
  always #5 CLOCK = ~CLOCK;
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    checks++;
    if (s !== e)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic summarize;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    u_host.xfer(a, d, 1'b1);
  endtask : wr
  // The expected byte is noted first; the monitor below pairs it with the answer.
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_host.xfer(a, 8'h00, 1'b0);
  endtask : rd
  task automatic pg(input logic [8:0] i, input logic [7:0] e);
    @(posedge CLOCK);
    #1;
    PAGE_RD_INDEX = i;
    repeat (2) @(posedge CLOCK);
    #1;
    chk("page", {8'h00, PAGE_RD_DATA}, {8'h00, e});
  endtask : pg
  always @(posedge CLOCK)
    if (HOST_RVALID === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk("unexpected rvalid", 16'h0001, 16'h0000);
      else
        chk("rdata", {8'h00, HOST_RDATA}, {8'h00, exp_q.pop_front()});
    end
  initial
  begin
    void'($urandom(75));
    {FIELD_TICK, WIN1_ACTIVE, WIN2_ACTIVE, RESET_N} = '0;
    {PAGE_RD_INDEX, PAL_COLOR, PAL_INDEX} = '0;
    repeat (10) @(posedge CLOCK);
    #1;
    RESET_N = 1'b1;
    chk("ppl reset", {6'h00, PIXELS_PER_LINE}, 16'h0200);
    rd(ofc_pkg::ADDR_FRAME_ONE, 8'h00);
    rd(16'h8402, 8'h00);
    wr(ofc_pkg::ADDR_FRAME_ONE, 8'he7);
    rd(ofc_pkg::ADDR_FRAME_ONE, 8'h07);
    for (int k = 0; k < 8; k++)
    begin
      wr(ofc_pkg::ADDR_FRAME_ONE, 8'(k));
      WIN1_ACTIVE = 1'($urandom);
      WIN2_ACTIVE = (k == 7) ? 1'b1 : 1'($urandom);
      @(posedge CLOCK);
      #1;
      chk("osd_on", 16'(OSD_ON), 16'(k[0]));
      chk("win1", 16'(WIN1_SHOW), 16'(k[0] & k[1] & WIN1_ACTIVE));
      chk("win2", 16'(WIN2_SHOW), 16'(k[0] & k[2] & WIN2_ACTIVE));
    end
    for (int k = 0; k < 8; k++)
    begin
      wr(ofc_pkg::ADDR_FRAME_TWO, {3'(k), 5'h00});
      @(posedge CLOCK);
      #1;
      chk("ppl", {6'h00, PIXELS_PER_LINE}, 16'h0200 + 16'(k * 64));
      rd(ofc_pkg::ADDR_FRAME_TWO, {3'(k), 5'h00});
    end
    for (int t = 0; t < 2; t++)
    begin
      wr(ofc_pkg::ADDR_FRAME_ONE, {3'h0, 1'(t), 4'h1});
      for (int i = 0; i < 16; i++)
      begin
        PAL_INDEX = 4'(i);
        PAL_COLOR = ($urandom % 2) ? 9'h000 : 9'($urandom);
        @(posedge CLOCK);
        #1;
        chk("transp", 16'(PAL_TRANSPARENT), 16'(t == 0 && PAL_COLOR == 9'h000 && i < 8));
      end
    end
    wr(ofc_pkg::ADDR_FRAME_TWO, 8'h01);
    for (int i = 1; i <= 8; i++)
    begin
      @(posedge CLOCK);
      #1;
      FIELD_TICK = 1'b1;
      @(posedge CLOCK);
      #1;
      FIELD_TICK = 1'b0;
      @(posedge CLOCK);
      #1;
      chk("blink", 16'(BLINK_PHASE), 16'(i >= 4 && i < 8));
    end
    d0 = 8'($urandom) | 8'h01;
    d1 = 8'($urandom) | 8'h80;
    wr(ofc_pkg::ADDR_PAGE_BASE, d0);
    wr(ofc_pkg::ADDR_PAGE_LAST, d1);
    pg(9'h000, d0);
    pg(9'h1ff, d1);
    // Slow host during the clear; a zero written to the clear bit must not abort it.
    u_host.slow = 2;
    wr(ofc_pkg::ADDR_FRAME_ONE, 8'h0f);
    t0 = $time;
    chk("busy", 16'(CLEAR_BUSY), 16'h0001);
    rd(ofc_pkg::ADDR_FRAME_ONE, 8'h0f);
    wr(ofc_pkg::ADDR_PAGE_LAST, 8'h5a);
    wr(ofc_pkg::ADDR_FRAME_ONE, 8'h07);
    rd(ofc_pkg::ADDR_FRAME_ONE, 8'h0f);
    u_host.slow = 0;
    n = 0;
    while (CLEAR_BUSY !== 1'b0 && n < 600)
    begin
      @(posedge CLOCK);
      #1;
      n++;
    end
    if (n >= 600)
      chk("clear timeout", 16'h0001, 16'h0000);
    else
    begin
      chk("clear cycles", 16'(($time - t0) / 10), 16'(ofc_pkg::PAGE_DEPTH));
      rd(ofc_pkg::ADDR_FRAME_ONE, 8'h07);
      pg(9'h000, 8'h00);
      pg(9'h1ff, 8'h00);
    end
    repeat (3) @(posedge CLOCK);
    chk("pending reads", 16'(exp_q.size()), 16'h0000);
    summarize();
  end
endmodule : osd_frame_control_regs_test
